// ### srps_pkg.sv
// Shared constants, encodings and field layouts of the system register and pointer stack.
package srps_pkg;

	// Data memory window of the system control block.
	localparam logic [6:0] SRPS_ADDR_PTR_TOP = 7'h74;
	localparam logic [6:0] SRPS_ADDR_PTR_UPPER = 7'h75;
	localparam logic [6:0] SRPS_ADDR_PTR_LOWER = 7'h76;
	localparam logic [6:0] SRPS_ADDR_PTR_BOTTOM = 7'h77;
	localparam logic [6:0] SRPS_ADDR_WINDOW = 7'h78;
	localparam logic [6:0] SRPS_ADDR_BANK = 7'h79;
	localparam logic [6:0] SRPS_ADDR_IDX_HIGH = 7'h7A;
	localparam logic [6:0] SRPS_ADDR_IDX_MID = 7'h7B;
	localparam logic [6:0] SRPS_ADDR_IDX_LOW = 7'h7C;
	localparam logic [6:0] SRPS_ADDR_GBP_HIGH = 7'h7D;
	localparam logic [6:0] SRPS_ADDR_GBP_LOW = 7'h7E;
	localparam logic [6:0] SRPS_ADDR_STATUS = 7'h7F;

	// Writable bits of each nibble; every other bit is a fixed zero.
	localparam logic [3:0] SRPS_MASK_PTR_TOP = 4'h0;
	localparam logic [3:0] SRPS_MASK_PTR_UPPER = 4'h3;
	localparam logic [3:0] SRPS_MASK_FULL = 4'hF;
	localparam logic [3:0] SRPS_MASK_BANK = 4'h0;
	localparam logic [3:0] SRPS_MASK_IDX_HIGH = 4'h8;
	localparam logic [3:0] SRPS_MASK_IDX_MID = 4'h7;
	localparam logic [3:0] SRPS_MASK_GBP_HIGH = 4'h1;

	// Reset values.
	localparam logic [3:0] SRPS_NIBBLE_RESET = 4'h0;
	localparam logic [9:0] SRPS_PTR_RESET = 10'h000;
	localparam logic [2:0] SRPS_LEVEL_RESET = 3'h5;

	// Pointer and stack geometry.
	localparam int SRPS_PTR_BITS = 10;
	localparam int SRPS_STACK_DEPTH = 5;
	localparam logic [2:0] SRPS_LEVEL_MAX = 3'h5;

	// Operations issued by the instruction sequencer.
	typedef enum logic [3:0] {
		SRPS_OP_NONE = 4'h0,
		SRPS_OP_CALL = 4'h1,
		SRPS_OP_CALL_IND = 4'h2,
		SRPS_OP_JUMP_IND = 4'h3,
		SRPS_OP_RET = 4'h4,
		SRPS_OP_TABLE = 4'h5,
		SRPS_OP_PUSH = 4'h6,
		SRPS_OP_POP = 4'h7,
		SRPS_OP_INC = 4'h8,
		SRPS_OP_PUT = 4'h9,
		SRPS_OP_GET = 4'hA,
		SRPS_OP_INTR = 4'hB,
		SRPS_OP_RETI = 4'hC
	} srps_op_e;

	// Phases of the sequencing; the table fetch owns the second one.
	typedef enum logic [1:0] {
		SRPS_PH_IDLE = 2'b00,
		SRPS_PH_FETCH2 = 2'b01
	} srps_phase_e;

endpackage

// ### srps_level_ctr.sv
// Stack level counter with its fault detection.
`timescale 1ns/1ps
module srps_level_ctr
	import srps_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Count requests.
	input wire logic i_dec,
	input wire logic i_inc,
	// Counter state.
	output logic [2:0] o_level,
	output logic o_fault
);

	typedef struct packed {
		logic [2:0] level;
		logic fault;
	} srps_ctr_s;

	srps_ctr_s s;
	srps_ctr_s next_s;

	// A level above the stack depth reloads the reset value and flags an internal reset.
	always_comb
	begin
		next_s = s;
		next_s.fault = (s.level > SRPS_LEVEL_MAX);
		if (s.level > SRPS_LEVEL_MAX)
		begin
			next_s.level = SRPS_LEVEL_RESET;
		end
		else if (i_dec)
		begin
			next_s.level = s.level - 3'h1;
		end
		else if (i_inc)
		begin
			next_s.level = s.level + 3'h1;
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s <= '{level: SRPS_LEVEL_RESET, fault: 1'b0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign o_level = s.level;
	assign o_fault = s.fault;

endmodule

// ### srps_addr_stack.sv
// Address stack entries with one write port and one asynchronous read port.
`timescale 1ns/1ps
module srps_addr_stack
	import srps_pkg::*;
#(
	parameter int DEPTH = SRPS_STACK_DEPTH,
	parameter int WIDTH = SRPS_PTR_BITS
)
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Write port.
	input wire logic i_we,
	input wire logic [2:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	// Read port.
	input wire logic [2:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
	} srps_stk_s;

	srps_stk_s s;
	srps_stk_s next_s;

	// Writes outside the existing entries are dropped.
	always_comb
	begin
		next_s = s;
		for (int i = 0; i < DEPTH; i++)
		begin
			if (i_we && (int'(i_waddr) == i))
			begin
				next_s.entry[i] = i_wdata;
			end
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Out-of-range reads return zero.
	assign o_rdata = (int'(i_raddr) < DEPTH) ? s.entry[i_raddr] : '0;

endmodule

// ### srps_system_control_block.sv
// System control block: pointer register, mapped nibbles and address stack sequencing.
`timescale 1ns/1ps
module srps_system_control_block
	import srps_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Operation request from the sequencer.
	input wire logic [3:0] i_op,
	input wire logic [9:0] i_pc,
	input wire logic [9:0] i_target,
	// Data memory access.
	input wire logic i_dm_rd,
	input wire logic i_dm_wr,
	input wire logic [6:0] i_dm_addr,
	input wire logic [3:0] i_dm_wdata,
	output logic o_dm_rvalid,
	output logic [3:0] o_dm_rdata,
	// Program counter control.
	output logic o_pc_load,
	output logic [9:0] o_pc_value,
	// Program memory read.
	output logic o_rom_rd,
	output logic [9:0] o_rom_addr,
	input wire logic [15:0] i_rom_data,
	// Word buffer exchange.
	input wire logic [15:0] i_buf_word,
	output logic o_buf_we,
	output logic [15:0] o_buf_word,
	// Status.
	output logic o_busy,
	output logic [2:0] o_stack_level,
	output logic o_fault_reset,
	output logic o_index_enable,
	output logic o_row_ptr_enable
);

	typedef struct packed {
		srps_phase_e phase;
		logic [9:0] ptr;
		logic [3:0] wr;
		logic [3:0] ixh;
		logic [3:0] ixm;
		logic [3:0] index_low_nibble;
		logic [3:0] general_bank_ptr_high;
		logic [3:0] general_bank_ptr_low;
		logic [3:0] status_flags_word;
		logic dm_rvalid;
		logic [3:0] dm_rdata;
		logic pc_load;
		logic [9:0] pc_value;
		logic rom_rd;
		logic [9:0] rom_addr;
		logic buf_we;
		logic [15:0] buf_word;
		logic busy;
		logic fault;
		logic [2:0] level;
	} srps_main_s;

	srps_main_s s;
	srps_main_s next_s;
	srps_main_s reset_s;

	logic lvl_dec;
	logic lvl_inc;
	logic [2:0] lvl;
	logic lvl_fault;
	logic stk_we;
	logic [2:0] stk_waddr;
	logic [9:0] stk_wdata;
	logic [9:0] stk_rdata;
	logic dm_hit;
	logic [3:0] dm_view;
	srps_op_e op;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules.

	// Stack level counter.
	srps_level_ctr u_level
	(
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_dec(lvl_dec),
		.i_inc(lvl_inc),
		.o_level(lvl),
		.o_fault(lvl_fault)
	);

	// Address stack storage.
	srps_addr_stack #(
		.DEPTH(SRPS_STACK_DEPTH),
		.WIDTH(SRPS_PTR_BITS)
	) u_stack
	(
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_we(stk_we),
		.i_waddr(stk_waddr),
		.i_wdata(stk_wdata),
		.i_raddr(lvl),
		.o_rdata(stk_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Data memory view.

	// The block claims the top twelve nibbles of data memory.
	assign dm_hit = (i_dm_addr >= SRPS_ADDR_PTR_TOP);
	assign op = srps_op_e'(i_op);
	// A pushed entry lands at the level after the decrement.
	assign stk_waddr = lvl - 3'h1;

	// Nibble as seen by a read; fixed-zero bits are forced low here.
	always_comb
	begin
		case (i_dm_addr)
			SRPS_ADDR_PTR_TOP: dm_view = SRPS_NIBBLE_RESET;
			SRPS_ADDR_PTR_UPPER: dm_view = {2'h0, s.ptr[9:8]};
			SRPS_ADDR_PTR_LOWER: dm_view = s.ptr[7:4];
			SRPS_ADDR_PTR_BOTTOM: dm_view = s.ptr[3:0];
			SRPS_ADDR_WINDOW: dm_view = s.wr;
			SRPS_ADDR_BANK: dm_view = SRPS_NIBBLE_RESET & SRPS_MASK_BANK;
			SRPS_ADDR_IDX_HIGH: dm_view = s.ixh & SRPS_MASK_IDX_HIGH;
			SRPS_ADDR_IDX_MID: dm_view = s.ixm & SRPS_MASK_IDX_MID;
			SRPS_ADDR_IDX_LOW: dm_view = s.index_low_nibble;
			SRPS_ADDR_GBP_HIGH: dm_view = s.general_bank_ptr_high & SRPS_MASK_GBP_HIGH;
			SRPS_ADDR_GBP_LOW: dm_view = s.general_bank_ptr_low;
			SRPS_ADDR_STATUS: dm_view = s.status_flags_word;
			default: dm_view = SRPS_NIBBLE_RESET;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset image of the internal fault reset; the pin reset loads the same values itself.

	always_comb
	begin
		reset_s = '0;
		reset_s.phase = SRPS_PH_IDLE;
		reset_s.ptr = SRPS_PTR_RESET;
		reset_s.level = SRPS_LEVEL_RESET;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: data memory access first, then the sequencer operation.

	always_comb
	begin
		next_s = s;
		next_s.pc_load = 1'b0;
		next_s.rom_rd = 1'b0;
		next_s.buf_we = 1'b0;
		next_s.dm_rvalid = 1'b0;
		next_s.fault = lvl_fault;
		next_s.level = lvl;
		lvl_dec = 1'b0;
		lvl_inc = 1'b0;
		stk_we = 1'b0;
		stk_wdata = i_pc;

		// Reads capture the current view, so earlier pointer updates are visible.
		if (i_dm_rd && dm_hit)
		begin
			next_s.dm_rvalid = 1'b1;
			next_s.dm_rdata = dm_view;
		end

		// Masked nibble writes; fixed-zero bits keep their zero.
		if (i_dm_wr && dm_hit)
		begin
			case (i_dm_addr)
				SRPS_ADDR_PTR_UPPER: next_s.ptr[9:8] = i_dm_wdata[1:0];
				SRPS_ADDR_PTR_LOWER: next_s.ptr[7:4] = i_dm_wdata;
				SRPS_ADDR_PTR_BOTTOM: next_s.ptr[3:0] = i_dm_wdata;
				SRPS_ADDR_WINDOW: next_s.wr = i_dm_wdata;
				SRPS_ADDR_IDX_HIGH: next_s.ixh = i_dm_wdata & SRPS_MASK_IDX_HIGH;
				SRPS_ADDR_IDX_MID: next_s.ixm = i_dm_wdata & SRPS_MASK_IDX_MID;
				SRPS_ADDR_IDX_LOW: next_s.index_low_nibble = i_dm_wdata & SRPS_MASK_FULL;
				SRPS_ADDR_GBP_HIGH: next_s.general_bank_ptr_high = i_dm_wdata & SRPS_MASK_GBP_HIGH;
				SRPS_ADDR_GBP_LOW: next_s.general_bank_ptr_low = i_dm_wdata;
				SRPS_ADDR_STATUS: next_s.status_flags_word = i_dm_wdata;
				default: next_s.wr = next_s.wr; // Top nibble and bank ignore writes.
			endcase
		end

		case (s.phase)
			SRPS_PH_IDLE:
			begin
				case (op)
					// Direct call or interrupt: stack the return address, jump.
					SRPS_OP_CALL, SRPS_OP_INTR:
					begin
						lvl_dec = 1'b1;
						stk_we = 1'b1;
						next_s.pc_load = 1'b1;
						next_s.pc_value = i_target;
					end
					// Indirect call through the pointer.
					SRPS_OP_CALL_IND:
					begin
						lvl_dec = 1'b1;
						stk_we = 1'b1;
						next_s.pc_load = 1'b1;
						next_s.pc_value = s.ptr;
					end
					// Indirect jump through the pointer.
					SRPS_OP_JUMP_IND:
					begin
						next_s.pc_load = 1'b1;
						next_s.pc_value = s.ptr;
					end
					// Returns restore the program counter, then count up.
					SRPS_OP_RET, SRPS_OP_RETI:
					begin
						next_s.pc_load = 1'b1;
						next_s.pc_value = stk_rdata;
						lvl_inc = 1'b1;
					end
					// First table cycle: stack the counter, jump to the pointer, read ROM.
					SRPS_OP_TABLE:
					begin
						lvl_dec = 1'b1;
						stk_we = 1'b1;
						next_s.pc_load = 1'b1;
						next_s.pc_value = s.ptr;
						next_s.rom_rd = 1'b1;
						next_s.rom_addr = s.ptr;
						next_s.busy = 1'b1;
						next_s.phase = SRPS_PH_FETCH2;
					end
					// Save the pointer at the decremented level.
					SRPS_OP_PUSH:
					begin
						lvl_dec = 1'b1;
						stk_we = 1'b1;
						stk_wdata = s.ptr;
					end
					// Restore the pointer from the current level, then count up.
					SRPS_OP_POP:
					begin
						next_s.ptr = stk_rdata;
						lvl_inc = 1'b1;
					end
					// Increment the whole pointer within its ten bits.
					SRPS_OP_INC:
					begin
						next_s.ptr = s.ptr + 10'h001;
					end
					// Pointer to buffer with the fixed upper bits as zero.
					SRPS_OP_PUT:
					begin
						next_s.buf_we = 1'b1;
						next_s.buf_word = {6'h00, s.ptr};
					end
					// Buffer to pointer; the fixed upper bits drop away.
					SRPS_OP_GET:
					begin
						next_s.ptr = i_buf_word[9:0];
					end
					default:
					begin
						next_s.phase = SRPS_PH_IDLE;
					end
				endcase
			end
			// Second table cycle: buffer the word, return, count up.
			SRPS_PH_FETCH2:
			begin
				next_s.buf_we = 1'b1;
				next_s.buf_word = i_rom_data;
				next_s.pc_load = 1'b1;
				next_s.pc_value = stk_rdata;
				lvl_inc = 1'b1;
				next_s.busy = 1'b0;
				next_s.phase = SRPS_PH_IDLE;
			end
			default:
			begin
				next_s.phase = SRPS_PH_IDLE;
				next_s.busy = 1'b0;
			end
		endcase

		// An internal reset returns the block to its reset image, except that the window nibble keeps its value.
		if (lvl_fault)
		begin
			next_s = reset_s;
			next_s.fault = 1'b1;
			next_s.level = SRPS_LEVEL_RESET;
			next_s.wr = s.wr;
			lvl_dec = 1'b0;
			lvl_inc = 1'b0;
			stk_we = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			s <= '{phase: SRPS_PH_IDLE, level: SRPS_LEVEL_RESET, default: '0};
		end
		else
		begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all from the state register.

	assign o_dm_rvalid = s.dm_rvalid;
	assign o_dm_rdata = s.dm_rdata;
	assign o_pc_load = s.pc_load;
	assign o_pc_value = s.pc_value;
	assign o_rom_rd = s.rom_rd;
	assign o_rom_addr = s.rom_addr;
	assign o_buf_we = s.buf_we;
	assign o_buf_word = s.buf_word;
	assign o_busy = s.busy;
	assign o_stack_level = s.level;
	assign o_fault_reset = s.fault;
	assign o_index_enable = s.status_flags_word[0];
	assign o_row_ptr_enable = s.ixh[3];

endmodule

// ### srps_system_control_block_sva.sv
// Port-level checks of the system register and pointer stack block.
`timescale 1ns/1ps
module srps_system_control_block_sva
	import srps_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Requests.
	input wire logic [3:0] i_op,
	input wire logic i_dm_rd,
	input wire logic [6:0] i_dm_addr,
	// Answers.
	input wire logic o_dm_rvalid,
	input wire logic [3:0] o_dm_rdata,
	input wire logic o_pc_load,
	input wire logic [9:0] o_pc_value,
	input wire logic o_rom_rd,
	input wire logic [9:0] o_rom_addr,
	input wire logic o_buf_we,
	input wire logic [15:0] o_buf_word,
	input wire logic o_busy,
	input wire logic o_fault_reset
);
	// All checks run on the core clock and rest while reset is held.
	default clocking
		@(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	////////////////////////////////////////////////////////////////////////////////////////
	// Program flow answers one cycle after an operation is taken.
	a_jump_load: assert property ((i_op == SRPS_OP_JUMP_IND && !o_busy) |=> o_pc_load)
		else $error("indirect jump gave no load");
	a_call_load: assert property ((i_op == SRPS_OP_CALL_IND && !o_busy) |=> o_pc_load)
		else $error("indirect call gave no load");
	a_fetch_start: assert property ((i_op == SRPS_OP_TABLE && !o_busy) |=>
		o_busy && o_rom_rd && o_pc_load)
		else $error("table fetch first cycle wrong");
	a_fetch_end: assert property (o_busy |=> !o_busy && !o_rom_rd)
		else $error("table fetch longer than two cycles");
	a_fetch_addr: assert property (o_rom_rd |-> o_rom_addr == o_pc_value)
		else $error("program word read away from the pointer");
	a_put_word: assert property ((i_op == SRPS_OP_PUT && !o_busy) |=>
		o_buf_we && o_buf_word[15:10] == 6'h00)
		else $error("pointer to buffer word wrong");

	////////////////////////////////////////////////////////////////////////////////////////
	// Data memory reads of the mapped window and the fixed-zero bits, and the one-cycle fault reset pulse.
	a_read_answer: assert property ((i_dm_rd && i_dm_addr >= 7'h74) |=> o_dm_rvalid)
		else $error("mapped read not answered");
	a_top_zero: assert property ((o_dm_rvalid && $past(i_dm_addr) == SRPS_ADDR_PTR_TOP)
		|-> o_dm_rdata == 4'h0)
		else $error("top pointer nibble not zero");
	a_upper_bits: assert property ((o_dm_rvalid && $past(i_dm_addr) == SRPS_ADDR_PTR_UPPER)
		|-> o_dm_rdata[3:2] == 2'h0)
		else $error("upper pointer nibble fixed bits set");
	a_fault_pulse: assert property (o_fault_reset |=> !o_fault_reset)
		else $error("fault reset longer than one cycle");
endmodule
bind srps_system_control_block srps_system_control_block_sva chk (.i_core_clk, .i_nrst, .i_op, .i_dm_rd, .i_dm_addr,
	.o_dm_rvalid, .o_dm_rdata, .o_pc_load, .o_pc_value, .o_rom_rd, .o_rom_addr, .o_buf_we,
	.o_buf_word, .o_busy, .o_fault_reset);

// ### srps_rom_model.sv
// Program memory model answering the table fetch reads.
`timescale 1ns/1ps
module srps_rom_model
	import srps_pkg::*;
(
	// Read request.
	input wire logic i_rd,
	input wire logic [9:0] i_addr,
	// Program word.
	output logic [15:0] o_word
);
	// Outside a read the word is inverted so a late sample never matches.
	assign o_word = i_rd ? {6'h2D, i_addr} : ~{6'h2D, i_addr};
endmodule

// ### system_register_and_pointer_stack_test.sv
// Self-checking bench of the system register and pointer stack block.
`timescale 1ns/1ps
module system_register_and_pointer_stack_test
	import srps_pkg::*;
;
	logic i_core_clk = 1'h0, i_nrst = 1'h0, i_dm_rd = 1'h0, i_dm_wr = 1'h0;
	logic [3:0] i_op = 4'h0, i_dm_wdata = 4'h0, o_dm_rdata;
	logic [9:0] i_pc = 10'h000, i_target = 10'h000, o_pc_value, o_rom_addr;
	logic [6:0] i_dm_addr = 7'h00;
	logic [15:0] i_buf_word = 16'h0000, i_rom_data, o_buf_word;
	logic o_dm_rvalid, o_pc_load, o_rom_rd, o_buf_we, o_busy, o_fault_reset, o_index_enable;
	logic o_row_ptr_enable;
	logic [2:0] o_stack_level;
	int n_mismatch = 0, check_count = 0;

	////////////////////////////////////////////////////////////////////////////////////////
	// Clock, block and program memory.
	always #2.5 i_core_clk = ~i_core_clk;
	srps_system_control_block dut (.i_core_clk, .i_nrst, .i_op, .i_pc, .i_target, .i_dm_rd, .i_dm_wr,
		.i_dm_addr, .i_dm_wdata, .o_dm_rvalid, .o_dm_rdata, .o_pc_load, .o_pc_value, .o_rom_rd,
		.o_rom_addr, .i_rom_data, .i_buf_word, .o_buf_we, .o_buf_word, .o_busy, .o_stack_level,
		.o_fault_reset, .o_index_enable, .o_row_ptr_enable);
	srps_rom_model rom (.i_rd(o_rom_rd), .i_addr(o_rom_addr), .o_word(i_rom_data));

	////////////////////////////////////////////////////////////////////////////////////////
	// Compares one result and counts it.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Issues one operation; requests rise at a falling edge and drop at the taking edge.
	task automatic op(input logic [3:0] code);
		i_op = code;
		@(posedge i_core_clk);
		i_op <= SRPS_OP_NONE;
		@(negedge i_core_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [3:0] d);
		i_dm_wr = 1'b1;
		i_dm_addr = a;
		i_dm_wdata = d;
		@(posedge i_core_clk);
		i_dm_wr <= 1'b0;
		@(negedge i_core_clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [3:0] exp, input logic valid);
		i_dm_rd = 1'b1;
		i_dm_addr = a;
		@(posedge i_core_clk);
		i_dm_rd <= 1'b0;
		@(negedge i_core_clk);
		chk(16'(o_dm_rvalid), 16'(valid), "read valid");
		if (valid)
			chk(16'(o_dm_rdata), 16'(exp), "read data");
	endtask
	task automatic setp(input logic [9:0] v);
		wr(SRPS_ADDR_PTR_UPPER, {2'h0, v[9:8]});
		wr(SRPS_ADDR_PTR_LOWER, v[7:4]);
		wr(SRPS_ADDR_PTR_BOTTOM, v[3:0]);
	endtask
	task automatic rdp(input logic [9:0] v);
		rd(SRPS_ADDR_PTR_TOP, 4'h0, 1'b1);
		rd(SRPS_ADDR_PTR_UPPER, {2'h0, v[9:8]}, 1'b1);
		rd(SRPS_ADDR_PTR_LOWER, v[7:4], 1'b1);
		rd(SRPS_ADDR_PTR_BOTTOM, v[3:0], 1'b1);
	endtask
	// The level copy lags the counter by one cycle.
	task automatic lvl(input logic [2:0] v);
		@(negedge i_core_clk);
		chk(16'(o_stack_level), 16'(v), "level");
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_map();
		logic [3:0] m [12] = '{4'h0, 4'h3, 4'hF, 4'hF, 4'hF, 4'h0, 4'h8, 4'h7, 4'hF, 4'h1, 4'hF, 4'hF};
		rdp(10'h000);
		chk(16'(o_stack_level), 16'h5, "reset level");
		for (int k = 0; k < 12; k++)
		begin
			wr(7'(8'h74 + k), 4'hF);
			rd(7'(8'h74 + k), m[k], 1'b1);
		end
		chk(16'({o_row_ptr_enable, o_index_enable}), 16'h3, "enables");
		rd(7'h73, 4'h0, 1'b0);
		$display("map test done");
	endtask
	task automatic t_flow();
		setp(10'h3FF);
		op(SRPS_OP_INC);
		rdp(10'h000);
		setp(10'h0FF);
		op(SRPS_OP_INC);
		rdp(10'h100);
		setp(10'h123);
		i_pc = 10'h2AA;
		op(SRPS_OP_JUMP_IND);
		chk(16'({o_pc_load, o_pc_value}), 16'h0523, "jump");
		op(SRPS_OP_CALL_IND);
		chk(16'(o_pc_value), 16'h0123, "call target");
		lvl(3'h4);
		op(SRPS_OP_RET);
		chk(16'(o_pc_value), 16'h02AA, "return");
		lvl(3'h5);
		// An interrupt stacks the same return address and jumps to its vector.
		i_target = 10'h3C0;
		op(SRPS_OP_INTR);
		chk(16'({o_pc_load, o_pc_value}), 16'h07C0, "vector");
		lvl(3'h4);
		op(SRPS_OP_RETI);
		chk(16'({o_pc_load, o_pc_value}), 16'h06AA, "interrupt return");
		lvl(3'h5);
		$display("flow test done");
	endtask
	task automatic t_table();
		setp(10'h155);
		i_pc = 10'h0C3;
		op(SRPS_OP_TABLE);
		chk(16'({o_rom_rd, o_busy, o_pc_load}), 16'h7, "fetch flags");
		chk(16'(o_rom_addr), 16'h0155, "fetch address");
		op(SRPS_OP_INC);
		chk(o_buf_word, {6'h2D, 10'h155}, "fetched word");
		chk(16'({o_buf_we, o_busy, o_pc_value}), 16'h08C3, "fetch end");
		rdp(10'h155);
		lvl(3'h5);
		$display("table test done");
	endtask
	task automatic t_stack();
		setp(10'h0AB);
		op(SRPS_OP_PUSH);
		lvl(3'h4);
		setp(10'h301);
		op(SRPS_OP_PUSH);
		setp(10'h000);
		op(SRPS_OP_POP);
		rdp(10'h301);
		op(SRPS_OP_POP);
		rdp(10'h0AB);
		lvl(3'h5);
		op(SRPS_OP_PUT);
		chk(16'(o_buf_we), 16'h1, "put strobe");
		chk(o_buf_word, 16'h00AB, "put word");
		i_buf_word = 16'hFD39;
		op(SRPS_OP_GET);
		rdp(10'h139);
		$display("stack test done");
	endtask
	task automatic t_fault();
		setp(10'h1E7);
		i_target = 10'h0F0;
		for (int k = 0; k < 5; k++)
			op(SRPS_OP_CALL);
		chk(16'({o_pc_load, o_pc_value}), 16'h04F0, "call target");
		lvl(3'h0);
		op(SRPS_OP_CALL);
		for (int k = 0; k < 8 && o_fault_reset !== 1'b1; k++)
			@(negedge i_core_clk);
		chk(16'(o_fault_reset), 16'h1, "fault reset");
		if (o_fault_reset !== 1'b1)
			give_verdict();
		lvl(3'h5);
		rdp(10'h000);
		$display("fault test done");
	endtask

	////////////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		repeat (6) @(negedge i_core_clk);
		i_nrst = 1'b1;
		t_map();
		t_flow();
		t_table();
		t_stack();
		t_fault();
		give_verdict();
	end
endmodule
